// ===== hdl/power_mode_direct_transition.sv
// Operating mode, CPU clock and direct transition controller with APB
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module power_mode_direct_transition
#(
  parameter int NUM_MODULES = pwr_mode_pkg::NUM_MODULES_DEFAULT,
  parameter int OSC_WAIT    = pwr_mode_pkg::OSC_WAIT_DEFAULT
)
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic      [31:0]            prdata,
  output logic                        pslverr,
  input  wire logic                   sleep_req,
  input  wire logic                   cpu_imask,
  input  wire logic                   wake_irq,
  input  wire logic                   watch_tick,
  input  wire logic                   subclk_present,
  output logic                        cpu_tick,
  output logic                        cpu_halt,
  output logic                        in_subactive,
  output logic                        dt_irq,
  output logic                        dt_busy,
  output logic      [NUM_MODULES-1:0] module_clk_en
);

  localparam logic [19:0] WAIT_BASE = 20'(OSC_WAIT);

  pwr_mode_pkg::system_control_first_t  ctrl1_ff;
  pwr_mode_pkg::system_control_first_t  nxt_ctrl1;
  pwr_mode_pkg::system_control_second_t ctrl2_ff;
  pwr_mode_pkg::system_control_second_t nxt_ctrl2;
  logic                                 dt_ie_ff;
  logic                                 nxt_dt_ie;
  logic [NUM_MODULES-1:0]               standby_ff;
  logic [NUM_MODULES-1:0]               nxt_standby;
  logic                                 pready_ff;
  logic                                 nxt_pready;
  logic [31:0]                          prdata_ff;
  logic [31:0]                          nxt_prdata;
  logic                                 pslverr_ff;
  logic                                 nxt_pslverr;
  logic                                 access;

  pwr_mode_pkg::pwr_state_t             state_ff;
  pwr_mode_pkg::pwr_state_t             nxt_state;
  logic [19:0]                          cnt_ff;
  logic [19:0]                          nxt_cnt;
  logic                                 use_sub_ff;
  logic                                 nxt_use_sub;
  logic                                 target_sub_ff;
  logic                                 nxt_target_sub;
  logic [2:0]                           act_sel_ff;
  logic [2:0]                           nxt_act_sel;
  logic [1:0]                           sub_sel_ff;
  logic [1:0]                           nxt_sub_sel;
  logic                                 locked_ff;
  logic                                 nxt_locked;
  logic                                 halt_ff;
  logic                                 nxt_halt;
  logic                                 dt_irq_ff;
  logic                                 nxt_dt_irq;
  logic                                 busy_ff;
  logic                                 nxt_busy;
  logic                                 tick;
  logic                                 wake_ok;

  // APB slave, one wait state in the access phase
  always_comb
  begin
    access      = psel & penable & ~pready_ff;
    nxt_pready  = access;
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    nxt_ctrl1   = ctrl1_ff;
    nxt_ctrl2   = ctrl2_ff;
    nxt_dt_ie   = dt_ie_ff;
    nxt_standby = standby_ff;
    if (access)
    begin
      case (paddr)
        pwr_mode_pkg::OFF_SYS_CTRL_FIRST:
        begin
          nxt_prdata = {27'h0, ctrl1_ff};
          if (pwrite)
          begin
            nxt_ctrl1 = pwr_mode_pkg::system_control_first_t'(pwdata[4:0]);
          end
        end
        pwr_mode_pkg::OFF_SYS_CTRL_SECOND:
        begin
          nxt_prdata = {26'h0, ctrl2_ff};
          if (pwrite)
          begin
            nxt_ctrl2 = pwr_mode_pkg::system_control_second_t'(pwdata[5:0]);
          end
        end
        pwr_mode_pkg::OFF_INT_ENABLE_1:
        begin
          nxt_prdata = {31'h0, dt_ie_ff};
          if (pwrite)
          begin
            nxt_dt_ie = pwdata[0];
          end
        end
        pwr_mode_pkg::OFF_MODULE_STANDBY:
        begin
          nxt_prdata = 32'(standby_ff);
          if (pwrite)
          begin
            nxt_standby = pwdata[NUM_MODULES-1:0];
          end
        end
        pwr_mode_pkg::OFF_MODE_STATUS:
        begin
          nxt_prdata = {19'h0, sub_sel_ff, act_sel_ff, locked_ff,
                        busy_ff, halt_ff, use_sub_ff, 1'b0, state_ff};
        end
        default:
        begin
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl1_ff   <= pwr_mode_pkg::RST_SYS_CTRL_FIRST;
      ctrl2_ff   <= pwr_mode_pkg::RST_SYS_CTRL_SECOND;
      dt_ie_ff   <= 1'b0;
      standby_ff <= '0;
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      ctrl1_ff   <= nxt_ctrl1;
      ctrl2_ff   <= nxt_ctrl2;
      dt_ie_ff   <= nxt_dt_ie;
      standby_ff <= nxt_standby;
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Mode sequencer
  always_comb
  begin
    nxt_state      = state_ff;
    nxt_cnt        = cnt_ff;
    nxt_use_sub    = use_sub_ff;
    nxt_target_sub = target_sub_ff;
    nxt_act_sel    = act_sel_ff;
    nxt_sub_sel    = sub_sel_ff;
    nxt_locked     = locked_ff;
    nxt_halt       = halt_ff;
    nxt_dt_irq     = 1'b0;
    nxt_busy       = busy_ff;
    // Subsleep without a subclock cannot be left by interrupt
    wake_ok = wake_irq & ~cpu_imask & ~locked_ff &
              ~((state_ff == pwr_mode_pkg::ST_SUBSLEEP) & ~subclk_present);
    case (state_ff)
      pwr_mode_pkg::ST_ACTIVE,
      pwr_mode_pkg::ST_SUBACTIVE:
      begin
        if (sleep_req)
        begin
          if (ctrl2_ff.direct_switch_flag & dt_ie_ff & ~cpu_imask)
          begin
            // Direct transition keeps the CPU running
            nxt_state      = pwr_mode_pkg::ST_DT_PRE;
            nxt_target_sub = ctrl1_ff.low_speed_select;
            nxt_cnt        = 20'h00000;
            nxt_busy       = 1'b1;
          end
          else
          begin
            // Disabled interrupt or mask falls back to sleep
            nxt_act_sel = ctrl2_ff.active_freq_sel;
            nxt_sub_sel = ctrl2_ff.sub_freq_sel;
            nxt_locked = ctrl2_ff.direct_switch_flag & cpu_imask;
            nxt_halt   = 1'b1;
            nxt_state  = ctrl1_ff.subsleep_select ?
                         pwr_mode_pkg::ST_SUBSLEEP : pwr_mode_pkg::ST_SLEEP;
          end
        end
      end
      pwr_mode_pkg::ST_DT_PRE:
      begin
        // Sleep and internal states on the pre-transition clock
        if (tick)
        begin
          if (cnt_ff + 20'h00001 >= pwr_mode_pkg::PRE_TICKS)
          begin
            nxt_use_sub = target_sub_ff;
            // New selections switch with the mode
            nxt_act_sel = ctrl2_ff.active_freq_sel;
            nxt_sub_sel = ctrl2_ff.sub_freq_sel;
            nxt_cnt     = 20'h00000;
            if (use_sub_ff & ~target_sub_ff)
            begin
              nxt_state = pwr_mode_pkg::ST_DT_WAIT;
            end
            else
            begin
              nxt_state  = pwr_mode_pkg::ST_DT_EXC;
              nxt_dt_irq = 1'b1;
            end
          end
          else
          begin
            nxt_cnt = cnt_ff + 20'h00001;
          end
        end
      end
      pwr_mode_pkg::ST_DT_WAIT:
      begin
        // Oscillator wait on the new system clock
        if (tick)
        begin
          if (cnt_ff + 20'h00001 >= (WAIT_BASE >> ctrl1_ff.osc_wait_sel))
          begin
            nxt_cnt    = 20'h00000;
            nxt_state  = pwr_mode_pkg::ST_DT_EXC;
            nxt_dt_irq = 1'b1;
          end
          else
          begin
            nxt_cnt = cnt_ff + 20'h00001;
          end
        end
      end
      pwr_mode_pkg::ST_DT_EXC:
      begin
        // Handling states on the new clock; the entry tick (dt_irq_ff cycle) is not counted
        if (tick & ~dt_irq_ff)
        begin
          if (cnt_ff + 20'h00001 >= pwr_mode_pkg::EXC_TICKS)
          begin
            nxt_cnt   = 20'h00000;
            nxt_busy  = 1'b0;
            nxt_state = use_sub_ff ? pwr_mode_pkg::ST_SUBACTIVE
                                   : pwr_mode_pkg::ST_ACTIVE;
          end
          else
          begin
            nxt_cnt = cnt_ff + 20'h00001;
          end
        end
      end
      pwr_mode_pkg::ST_SLEEP,
      pwr_mode_pkg::ST_SUBSLEEP:
      begin
        if (wake_ok)
        begin
          // Release mode follows the low speed select bit
          nxt_halt    = 1'b0;
          nxt_use_sub = ctrl1_ff.low_speed_select;
          nxt_state   = ctrl1_ff.low_speed_select ?
                        pwr_mode_pkg::ST_SUBACTIVE : pwr_mode_pkg::ST_ACTIVE;
        end
      end
      default:
      begin
        nxt_state = pwr_mode_pkg::ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff      <= pwr_mode_pkg::ST_ACTIVE;
      cnt_ff        <= 20'h00000;
      use_sub_ff    <= 1'b0;
      target_sub_ff <= 1'b0;
      act_sel_ff    <= 3'h0;
      sub_sel_ff    <= 2'h0;
      locked_ff     <= 1'b0;
      halt_ff       <= 1'b0;
      dt_irq_ff     <= 1'b0;
      busy_ff       <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      use_sub_ff    <= nxt_use_sub;
      target_sub_ff <= nxt_target_sub;
      act_sel_ff    <= nxt_act_sel;
      sub_sel_ff    <= nxt_sub_sel;
      locked_ff     <= nxt_locked;
      halt_ff       <= nxt_halt;
      dt_irq_ff     <= nxt_dt_irq;
      busy_ff       <= nxt_busy;
    end
  end

  // CPU clock enable from the applied selections
  cpu_tick_gen u_tick
  (
    .core_clk   (core_clk),
    .rst        (rst),
    .use_sub    (use_sub_ff),
    .act_sel    (act_sel_ff),
    .sub_sel    (sub_sel_ff),
    .watch_tick (watch_tick),
    .tick_ff    (tick)
  );

  module_clk_gate #(.NUM_MODULES(NUM_MODULES)) u_gate
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .standby   (standby_ff),
    .clk_en_ff (module_clk_en)
  );

  assign pready       = pready_ff;
  assign prdata       = prdata_ff;
  assign pslverr      = pslverr_ff;
  assign cpu_tick     = tick;
  assign cpu_halt     = halt_ff;
  assign in_subactive = use_sub_ff;
  assign dt_irq       = dt_irq_ff;
  assign dt_busy      = busy_ff;

endmodule // power_mode_direct_transition

// ===== hdl/pwr_mode_pkg.sv
// Package with register map, field layouts, states and timing counts
package pwr_mode_pkg;

  localparam logic [7:0] OFF_SYS_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] OFF_SYS_CTRL_SECOND = 8'h04;
  localparam logic [7:0] OFF_INT_ENABLE_1    = 8'h08;
  localparam logic [7:0] OFF_MODULE_STANDBY  = 8'h0C;
  localparam logic [7:0] OFF_MODE_STATUS     = 8'h10;

  localparam logic [4:0] RST_SYS_CTRL_FIRST  = 5'h00;
  localparam logic [5:0] RST_SYS_CTRL_SECOND = 6'h00;

  localparam int         SLEEP_EXEC_STATES   = 2;
  localparam int         INTERNAL_STATES     = 1;
  localparam int         EXC_STATES          = 14;
  localparam logic [19:0] PRE_TICKS          =
    20'(SLEEP_EXEC_STATES + INTERNAL_STATES);
  localparam logic [19:0] EXC_TICKS          = 20'(EXC_STATES);

  localparam int         OSC_WAIT_DEFAULT    = 8192;
  localparam int         NUM_MODULES_DEFAULT = 8;

  typedef struct packed {
    logic       low_speed_select;
    logic [2:0] osc_wait_sel;
    logic       subsleep_select;
  } system_control_first_t;

  typedef struct packed {
    logic       direct_switch_flag;
    logic [1:0] sub_freq_sel;
    logic [2:0] active_freq_sel;
  } system_control_second_t;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_SUBACTIVE,
    ST_DT_PRE,
    ST_DT_WAIT,
    ST_DT_EXC,
    ST_SLEEP,
    ST_SUBSLEEP
  } pwr_state_t;

endpackage

// ===== hdl/cpu_tick_gen.sv
// CPU clock enable divider for system and watch clock sources
`timescale 1ns/1ps
module cpu_tick_gen
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       use_sub,
  input  wire logic [2:0] act_sel,
  input  wire logic [1:0] sub_sel,
  input  wire logic       watch_tick,
  output logic            tick_ff
);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic       nxt_tick;
  logic [7:0] limit;
  logic       adv;

  always_comb
  begin
    limit    = 8'h00;
    adv      = 1'b1;
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (use_sub)
    begin
      // Watch clock divided by 8, 4 or 2
      case (sub_sel)
        2'h0:    limit = 8'h07;
        2'h1:    limit = 8'h03;
        default: limit = 8'h01;
      endcase
      adv = watch_tick;
    end
    else
    begin
      // System clock divided by two to the power of the selection
      limit = 8'((9'h001 << act_sel) - 9'h001);
    end
    if (adv)
    begin
      if (cnt_ff >= limit)
      begin
        nxt_cnt  = 8'h00;
        nxt_tick = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

endmodule // cpu_tick_gen

// ===== hdl/module_clk_gate.sv
// Per-module clock enables driven by module standby bits
`timescale 1ns/1ps
module module_clk_gate
#(
  parameter int NUM_MODULES = 8
)
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic [NUM_MODULES-1:0] standby,
  output logic      [NUM_MODULES-1:0] clk_en_ff
);

  logic [NUM_MODULES-1:0] nxt_clk_en;

  genvar i;
  generate
    for (i = 0; i < NUM_MODULES; i++)
    begin : g_mod
      // Standby bit at 1 stops the module clock, 0 restores it
      always_comb
      begin
        nxt_clk_en[i] = ~standby[i];
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      clk_en_ff <= '1;
    end
    else
    begin
      clk_en_ff <= nxt_clk_en;
    end
  end

endmodule // module_clk_gate

// ===== test/pwr_mode_asserts.sv
// Port checker for mode changes, transition timing and bus answers
`timescale 1ns/1ps
module pwr_mode_asserts
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_req,
  input wire logic cpu_imask,
  input wire logic wake_irq,
  input wire logic cpu_tick,
  input wire logic cpu_halt,
  input wire logic dt_busy,
  input wire logic dt_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       irq_seen_ff, nxt_irq_seen;
  logic [4:0] post_cnt_ff, nxt_post_cnt;
  // Counts new-clock ticks after the transition interrupt
  always_comb
  begin
    nxt_irq_seen = dt_busy & (irq_seen_ff | dt_irq);
    nxt_post_cnt = post_cnt_ff;
    if (!dt_busy)
      nxt_post_cnt = 5'h00;
    else if (irq_seen_ff && cpu_tick)
      nxt_post_cnt = post_cnt_ff + 5'h01;
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_seen_ff <= 1'b0;
      post_cnt_ff <= 5'h00;
    end
    else
    begin
      irq_seen_ff <= nxt_irq_seen;
      post_cnt_ff <= nxt_post_cnt;
    end
  end
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_busy_cause: assert property ($rose(dt_busy) |-> $past(sleep_req))
    else $error("transition without sleep");
  a_halt_cause: assert property ($rose(cpu_halt) |-> $past(sleep_req))
    else $error("halt without sleep");
  a_sleep_taken: assert property
    (sleep_req && !dt_busy && !cpu_halt |=> dt_busy || cpu_halt)
    else $error("sleep ignored");
  a_dt_no_halt: assert property (dt_busy |-> !cpu_halt)
    else $error("halt during transition");
  a_irq_in_busy: assert property (dt_irq |-> dt_busy ##1 !dt_irq)
    else $error("bad transition interrupt");
  a_wake_cause: assert property
    ($fell(cpu_halt) |-> $past(wake_irq) && !$past(cpu_imask))
    else $error("wake without request");
  a_exc_ticks: assert property
    ($fell(dt_busy) |-> post_cnt_ff == 5'h0E)
    else $error("wrong handling tick count");
endmodule // pwr_mode_asserts
bind power_mode_direct_transition pwr_mode_asserts pwr_mode_asserts_inst
(.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
 .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
 .cpu_imask(cpu_imask), .wake_irq(wake_irq), .cpu_tick(cpu_tick),
 .cpu_halt(cpu_halt), .dt_busy(dt_busy), .dt_irq(dt_irq));

// ===== test/cpu_core_model.sv
// CPU core stand-in that issues sleep instructions on tick boundaries
`timescale 1ns/1ps
module cpu_core_model
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic cpu_tick,
  input  wire logic cpu_halt,
  input  wire logic exec,
  input  wire logic mask_in,
  output logic      sleep_req,
  output logic      cpu_imask
);
  logic pend_ff;
  assign cpu_imask = mask_in;
  // A sleep instruction completes only on a CPU clock enable
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pend_ff   <= 1'b0;
      sleep_req <= 1'b0;
    end
    else
    begin
      sleep_req <= pend_ff & cpu_tick & ~cpu_halt & ~sleep_req;
      if (exec)
        pend_ff <= 1'b1;
      else if (sleep_req)
        pend_ff <= 1'b0;
    end
  end
endmodule // cpu_core_model

// ===== test/tb_power_mode_direct_transition.sv
// Testbench for the operating mode and direct transition controller
`timescale 1ns/1ps
module tb_power_mode_direct_transition;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, module_clk_en, v;
  logic [31:0] pwdata, prdata, rd;
  logic        wake_irq, subclk_present, exec, mask_in;
  logic        sleep_req, cpu_imask, cpu_tick, cpu_halt, in_subactive;
  logic        dt_irq, dt_busy, err;
  logic        irq_hit    = 1'b0;
  logic        watch_tick = 1'b0;
  logic [2:0]  a, o;
  logic [1:0]  s;
  logic [1:0]  wcnt       = 2'h0;
  int          fail_count, tests_run, n, p;
  int          cyc        = 0;
  power_mode_direct_transition #(.NUM_MODULES(8), .OSC_WAIT(16))
  power_mode_direct_transition_inst
  (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .sleep_req(sleep_req),
   .cpu_imask(cpu_imask), .wake_irq(wake_irq), .watch_tick(watch_tick),
   .subclk_present(subclk_present), .cpu_tick(cpu_tick),
   .cpu_halt(cpu_halt), .in_subactive(in_subactive), .dt_irq(dt_irq),
   .dt_busy(dt_busy), .module_clk_en(module_clk_en));
  cpu_core_model cpu_core_model_inst
  (.core_clk(core_clk), .rst(rst), .cpu_tick(cpu_tick),
   .cpu_halt(cpu_halt), .exec(exec), .mask_in(mask_in),
   .sleep_req(sleep_req), .cpu_imask(cpu_imask));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Watch clock tick every 4 cycles, cycle count and hang limit
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    wcnt <= wcnt + 2'h1;
    watch_tick <= (wcnt == 2'h3);
    if (exec === 1'b1)
      irq_hit <= 1'b0;
    else if (dt_irq === 1'b1)
      irq_hit <= 1'b1;
    if (cyc == 30000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task end_sim();
    $display("checks=%0d errors=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function int sub_div(input logic [1:0] sel);
    return (sel == 2'h0) ? 8 : (sel == 2'h1) ? 4 : 2;
  endfunction
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task cfg(input logic [4:0] c1, input logic [5:0] c2, input logic en);
    apb(1'b1, pwr_mode_pkg::OFF_SYS_CTRL_FIRST, {27'h0, c1});
    apb(1'b1, pwr_mode_pkg::OFF_SYS_CTRL_SECOND, {26'h0, c2});
    apb(1'b1, pwr_mode_pkg::OFF_INT_ENABLE_1, {31'h0, en});
  endtask
  task wait_for(input logic busy_sel, input logic val);
    int k;
    k = 0;
    while (k < 3000 && (busy_sel ? dt_busy : cpu_halt) !== val)
    begin
      @(posedge core_clk);
      k++;
    end
    chk(k < 3000, 32'h1);
  endtask
  task period(output int q);
    int k;
    k = 0;
    while (cpu_tick !== 1'b1 && k < 100)
    begin
      @(posedge core_clk);
      k++;
    end
    q = 0;
    do
    begin
      @(posedge core_clk);
      q++;
    end while (cpu_tick !== 1'b1 && q < 100);
  endtask
  task sleep_cmd();
    exec <= 1'b1;
    @(posedge core_clk);
    exec <= 1'b0;
  endtask
  task do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
  endtask
  task direct(input logic [2:0] wsel, output int q);
    n = cyc;
    sleep_cmd();
    wait_for(1'b1, 1'b1);
    chk(cpu_halt, 32'h0);
    wait_for(1'b1, 1'b0);
    chk(irq_hit, 32'h1);
    chk((cyc - n) >= (16 >> wsel) + 14, 32'h1);
    period(q);
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, wake_irq, exec} = '0;
    mask_in = 1'b0;
    subclk_present = 1'b1;
    rst = 1'b1;
    fail_count = 0;
    tests_run = 0;
    void'($urandom(46660));
    do_reset();
    chk(module_clk_en, 32'hFF);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
      chk(err, i == 5);
    end
    repeat (4)
    begin
      v = 8'($urandom);
      apb(1'b1, pwr_mode_pkg::OFF_MODULE_STANDBY, {24'h0, v});
      repeat (2) @(posedge core_clk);
      chk(module_clk_en, {24'h0, ~v});
      apb(1'b0, pwr_mode_pkg::OFF_MODULE_STANDBY, 32'h0);
      chk(rd, {24'h0, v});
    end
    a = 3'($urandom_range(1, 3));
    cfg(5'h00, {3'b100, a}, 1'b1);
    period(p);
    chk(p, 1);
    direct(3'h7, p);
    chk(p, 1 << a);
    chk(in_subactive, 32'h0);
    s = 2'($urandom);
    cfg(5'h10, {1'b1, s, a}, 1'b1);
    direct(3'h7, p);
    chk(in_subactive, 32'h1);
    chk(p, 4 * sub_div(s));
    o = 3'($urandom_range(0, 3));
    cfg({1'b0, o, 1'b0}, {1'b1, s, a}, 1'b1);
    direct(o, p);
    chk(in_subactive, 32'h0);
    chk(p, 1 << a);
    cfg(5'h10, 6'h20, 1'b0);
    sleep_cmd();
    wait_for(1'b0, 1'b1);
    chk(dt_busy, 32'h0);
    wake_irq <= 1'b1;
    wait_for(1'b0, 1'b0);
    wake_irq <= 1'b0;
    @(posedge core_clk);
    chk(in_subactive, 32'h1);
    mask_in <= 1'b1;
    cfg(5'h00, 6'h20, 1'b1);
    sleep_cmd();
    wait_for(1'b0, 1'b1);
    mask_in <= 1'b0;
    wake_irq <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(cpu_halt, 32'h1);
    wake_irq <= 1'b0;
    do_reset();
    cfg(5'h01, 6'h00, 1'b1);
    subclk_present <= 1'b0;
    sleep_cmd();
    wait_for(1'b0, 1'b1);
    wake_irq <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(cpu_halt, 32'h1);
    subclk_present <= 1'b1;
    wait_for(1'b0, 1'b0);
    chk(in_subactive, 32'h0);
    end_sim();
  end
endmodule // tb_power_mode_direct_transition
